/* verification/pic_core_model.sv */
// pic_core_model: core sequencer handshake and external stack memory
// assumes registered stack strobes from the controller on the same clock
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // call handshake
   input  wire logic                call_req,
   input  wire logic [3:0]          ack_delay,
   output var  logic                call_ack,
   // stack memory
   input  wire pic_pkg::pic_stack_t stack,
   output wire logic [7:0]          stack_data_in
);
   // ---------------------------------------------
   // acknowledge and memory
   // ---------------------------------------------
   logic [7:0] mem [256];
   logic [7:0] hold_reg;
   logic       hold_vld;
   logic [3:0] wait_cnt;
   always_ff @(posedge clk) begin
      call_ack <= 1'b0;
      hold_vld <= stack.rd;
      if (sys_rst || !call_req || call_ack) begin
         wait_cnt <= 4'h0;
      end else if (wait_cnt >= ack_delay) begin
         call_ack <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
      if (stack.wr) begin
         mem[stack.addr] <= stack.data;
      end
      if (sys_rst) begin
         hold_reg <= 8'h00;
      end else if (stack.rd) begin
         hold_reg <= mem[stack.addr];
      end
   end
   // read data stands two cycles, then shows the inverse
   assign stack_data_in = stack.rd ? mem[stack.addr] : (hold_vld ? hold_reg : ~hold_reg);
endmodule : pic_core_model
`default_nettype wire

/* verification/pic_top_assertions.sv */
// pic_top_assertions: port-level checks for the interrupt controller
// assumes one clock domain with sync reset; bound into pic_top below
`timescale 1ns/1ps
`default_nettype none
module pic_top_assertions (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  sys_rst,
   // register port
   input wire pic_pkg::pic_sfr_req_t sfr_req,
   input wire logic [7:0]            sfr_rdata,
   // core and stack side
   input wire logic                  call_ack,
   input wire logic                  call_req,
   input wire logic [15:0]           call_vector,
   input wire pic_pkg::pic_stack_t   stack,
   input wire logic [7:0]            stack_data_in,
   input wire logic [7:0]            bank_extension
);
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_prio_rsvd;
      $past(sfr_req.rd) && ($past(sfr_req.addr) == pic_pkg::ADDR_PRIO_LOW
         || $past(sfr_req.addr) == pic_pkg::ADDR_PRIO_HIGH) |-> sfr_rdata[7:6] == 2'b00;
   endproperty
   a_prio_rsvd: assert property (p_prio_rsvd) else $error("priority top bits set");
   property p_flagb_rsvd;
      $past(sfr_req.rd) && $past(sfr_req.addr) == pic_pkg::ADDR_FLAGS_B
         |-> sfr_rdata[5:2] == 4'h0;
   endproperty
   a_flagb_rsvd: assert property (p_flagb_rsvd) else $error("flags b unused bits set");
   property p_call_hold;
      call_req && !call_ack |=> call_req && $stable(call_vector);
   endproperty
   a_call_hold: assert property (p_call_hold) else $error("call dropped early");
   property p_call_drop;
      call_req && call_ack |=> !call_req;
   endproperty
   a_call_drop: assert property (p_call_drop) else $error("call held after ack");
   property p_vec_form;
      call_req |-> call_vector[2:0] == 3'h3 && call_vector <= 16'h00CB
         && call_vector != 16'h0073 && call_vector != 16'h007B;
   endproperty
   a_vec_form: assert property (p_vec_form) else $error("vector off table");
   property p_push_call;
      stack.wr |-> stack.data == bank_extension && !stack.rd ##1 call_req;
   endproperty
   a_push_call: assert property (p_push_call) else $error("push wrong or no call");
   property p_bank_load;
      stack.wr |=> bank_extension[7:4] == bank_extension[3:0] && !stack.wr;
   endproperty
   a_bank_load: assert property (p_bank_load) else $error("bank bits not loaded");
   property p_pop_load;
      stack.rd |=> bank_extension == $past(stack_data_in);
   endproperty
   a_pop_load: assert property (p_pop_load) else $error("pop not reloaded");
   property p_no_push_in_call;
      call_req |-> !stack.wr;
   endproperty
   a_no_push_in_call: assert property (p_no_push_in_call) else $error("entry while calling");
endmodule : pic_top_assertions
bind pic_top pic_top_assertions u_chk (.clk(clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
   .sfr_rdata(sfr_rdata), .call_ack(call_ack), .call_req(call_req), .call_vector(call_vector),
   .stack(stack), .stack_data_in(stack_data_in), .bank_extension(bank_extension));
`default_nettype wire

/* verification/pic_top_bench.sv */
// pic_top_bench: directed tests of the interrupt controller
// assumes pic_core_model answers calls and holds the stack memory
`timescale 1ns/1ps
`default_nettype none
module pic_top_bench;
   logic clk, sys_rst, chan_req, wake_req, ext0_pin, ext1_pin, call_ack, reti, call_req;
   logic [7:0]  periph_req_a, sfr_rdata, stack_data_in, bank_extension;
   logic [5:0]  std_req;
   logic [3:0]  edge_sel, ack_delay;
   logic [15:0] call_vector;
   pic_pkg::pic_sfr_req_t sfr_req;
   pic_pkg::pic_stack_t   stack;
   int n_mismatch = 0;
   int n_tests = 0;
   int pb[12] = '{7, 5, 4, 3, 2, 1, 0, 8, 9, 10, 11, 6};
   int eb[12] = '{4, 2, 4, 5, 2, 4, 5, 3, 5, 1, 3, 5};
   logic [7:0] ea[12] = '{8'hAB, 8'hA9, 8'hA9, 8'hA9, 8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hAB,
      8'hA9, 8'hA9, 8'hA8};
   pic_top u_dut (.clk(clk), .sys_rst(sys_rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
      .periph_req_a(periph_req_a), .channel_switch_req(chan_req),
      .converter_wakeup_req(wake_req), .std_req(std_req), .extra_ext0_pin(ext0_pin),
      .extra_ext1_pin(ext1_pin), .extra_edge_sel(edge_sel), .call_ack(call_ack), .reti(reti),
      .call_req(call_req), .call_vector(call_vector), .stack(stack),
      .stack_data_in(stack_data_in), .bank_extension(bank_extension));
   pic_core_model u_core (.clk(clk), .sys_rst(sys_rst), .call_req(call_req),
      .ack_delay(ack_delay), .call_ack(call_ack), .stack(stack), .stack_data_in(stack_data_in));
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      sfr_req.wr = 1'b0;
   endtask : sfr_wr
   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      sfr_req.rd = 1'b0;
      chk({8'h00, sfr_rdata}, {8'h00, exp});
   endtask : sfr_rd
   task automatic fire(input int k);
      @(negedge clk);
      periph_req_a = (k < 8) ? 8'h01 << k : 8'h00;
      chan_req = (k == 8);
      wake_req = (k == 9);
      ext0_pin = (k == 10);
      ext1_pin = (k == 11);
      @(negedge clk);
      {periph_req_a, chan_req, wake_req, ext0_pin, ext1_pin} = '0;
   endtask : fire
   task automatic wait_call(input logic [15:0] v);
      int i;
      i = 0;
      while (call_req !== 1'b1 && i < 40) begin
         @(negedge clk);
         i++;
      end
      chk({15'h0000, call_req}, 16'h0001);
      chk(call_vector, v);
      while (call_req !== 1'b0 && i < 80) begin
         @(negedge clk);
         i++;
      end
   endtask : wait_call
   task automatic no_call(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(negedge clk);
         seen = seen | call_req;
      end
      chk({15'h0000, seen}, 16'h0000);
   endtask : no_call
   task automatic ret;
      @(negedge clk);
      reti = 1'b1;
      @(negedge clk);
      reti = 1'b0;
      repeat (4) @(negedge clk);
   endtask : ret
   function automatic logic [15:0] exp_vec(input logic [7:0] a, input int b);
      int idx;
      idx = (a - 8'hA8) * 6 + b;
      return 16'h0003 + 16'(8 * idx) + ((idx >= 14) ? 16'h0010 : 16'h0000);
   endfunction : exp_vec
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   task automatic t_regs;
      sfr_rd(8'hC0, 8'h00);
      sfr_wr(8'hB8, 8'hFF);
      sfr_wr(8'hB9, 8'hFF);
      sfr_wr(8'hC8, 8'hFF);
      sfr_wr(8'hC0, 8'hFF);
      sfr_rd(8'hB8, 8'h3F);
      sfr_rd(8'hB9, 8'h3F);
      sfr_rd(8'hC8, 8'hC3);
      sfr_rd(8'hC0, 8'hFF);
      sfr_rd(8'hF3, 8'h00);
      for (int i = 0; i < 4; i++) sfr_wr(i[1] ? 8'hC0 + 8'(8 * i[0]) : 8'hB8 + 8'(i), 8'h00);
      sfr_rd(8'hC8, 8'h00);
      $display("t_regs finished");
   endtask : t_regs
   task automatic t_capture;
      @(negedge clk);
      {periph_req_a, chan_req, wake_req, ext0_pin, ext1_pin} = '1;
      @(negedge clk);
      {periph_req_a, chan_req, wake_req} = '0;
      edge_sel = 4'h5;
      repeat (4) @(negedge clk);
      sfr_rd(8'hC0, 8'hFF);
      sfr_rd(8'hC8, 8'hC0);
      sfr_wr(8'hC8, 8'h00);
      {ext0_pin, ext1_pin} = 2'b00;
      repeat (4) @(negedge clk);
      sfr_rd(8'hC8, 8'h03);
      sfr_wr(8'hC8, 8'h00);
      edge_sel = 4'hA;
      @(negedge clk);
      sfr_req = '{wr: 1'b1, rd: 1'b0, addr: 8'hC0, wdata: 8'h00};
      periph_req_a = 8'h01;
      @(negedge clk);
      sfr_req.wr = 1'b0;
      periph_req_a = 8'h00;
      sfr_rd(8'hC0, 8'h01);
      sfr_wr(8'hC0, 8'h00);
      $display("t_capture finished");
   endtask : t_capture
   task automatic t_vectors;
      for (int k = 0; k < 12; k++) begin
         sfr_wr(8'hA8, 8'h80);
         sfr_wr(ea[k], (8'h01 << eb[k]) | ((ea[k] == 8'hA8) ? 8'h80 : 8'h00));
         fire(pb[k]);
         wait_call(exp_vec(ea[k], eb[k]));
         if (pb[k] < 8) sfr_rd(8'hC0, 8'h01 << pb[k]);
         sfr_wr(8'hC0, 8'h00);
         sfr_wr(8'hC8, 8'h00);
         ret;
         sfr_wr(ea[k], 8'h00);
      end
      for (int g = 0; g < 6; g++) begin
         sfr_wr(8'hA8, 8'h80 | (8'h01 << g));
         std_req = 6'h01 << g;
         wait_call(exp_vec(8'hA8, g));
         std_req = 6'h00;
         ret;
      end
      $display("t_vectors finished");
   endtask : t_vectors
   task automatic t_order;
      sfr_wr(8'hB9, 8'h20);
      sfr_wr(8'hA8, 8'h87);
      sfr_wr(8'hAA, 8'h20);
      sfr_wr(8'hA9, 8'h04);
      @(negedge clk);
      periph_req_a = 8'h21;
      @(negedge clk);
      periph_req_a = 8'h00;
      std_req = 6'h07;
      wait_call(16'h009B);
      sfr_wr(8'hC0, 8'h20);
      ret;
      for (int g = 0; g < 3; g++) begin
         wait_call(exp_vec(8'hA8, g));
         std_req[g] = 1'b0;
         ret;
      end
      wait_call(16'h0043);
      sfr_wr(8'hC0, 8'h00);
      ret;
      $display("t_order finished");
   endtask : t_order
   task automatic t_preempt;
      sfr_wr(8'hB8, 8'h05);
      sfr_wr(8'hB9, 8'h02);
      sfr_wr(8'hA9, 8'h00);
      sfr_wr(8'hAA, 8'h00);
      std_req = 6'h01;
      wait_call(16'h0003);
      std_req = 6'h05;
      no_call(20);
      std_req = 6'h07;
      wait_call(16'h000B);
      std_req = 6'h05;
      ret;
      no_call(20);
      std_req = 6'h04;
      ret;
      wait_call(16'h0013);
      std_req = 6'h00;
      ret;
      sfr_wr(8'hA8, 8'h07);
      std_req = 6'h01;
      no_call(20);
      std_req = 6'h00;
      $display("t_preempt finished");
   endtask : t_preempt
   task automatic t_bank;
      sfr_wr(8'h95, 8'h05);
      sfr_wr(8'h94, 8'hA1);
      sfr_wr(8'h96, 8'h10);
      sfr_wr(8'hA8, 8'h81);
      std_req = 6'h01;
      wait_call(16'h0003);
      chk({8'h00, bank_extension}, 16'h0055);
      chk({8'h00, u_core.mem[8'h10]}, 16'h00A1);
      sfr_rd(8'h96, 8'h11);
      std_req = 6'h00;
      ret;
      chk({8'h00, bank_extension}, 16'h00A1);
      sfr_rd(8'h96, 8'h10);
      $display("t_bank finished");
   endtask : t_bank
   initial begin
      #60000;
      n_mismatch++;
      give_verdict;
   end
   initial begin
      sys_rst = 1'b1;
      sfr_req = '0;
      {periph_req_a, chan_req, wake_req, ext0_pin, ext1_pin, std_req, reti} = '0;
      edge_sel = 4'hA;
      ack_delay = 4'h0;
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      t_regs;
      t_capture;
      t_vectors;
      ack_delay = 4'h5;
      t_order;
      t_preempt;
      t_bank;
      give_verdict;
   end
endmodule : pic_top_bench
`default_nettype wire

/* verilog/pic_pkg.sv */
// pic_pkg: constants and types shared by the priority interrupt controller
// assumes an 8-bit special-function register port on the processor clock
package pic_pkg;
   // ------------------------------------------------------------
   // register addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_PRIO_LOW  = 8'hB8;
   localparam logic [7:0] ADDR_FLAGS_A   = 8'hC0;
   localparam logic [7:0] ADDR_FLAGS_B   = 8'hC8;
   localparam logic [7:0] ADDR_PRIO_HIGH = 8'hB9;
   localparam logic [7:0] ADDR_ENABLE_0  = 8'hA8;
   localparam logic [7:0] ADDR_ENABLE_1  = 8'hA9;
   localparam logic [7:0] ADDR_ENABLE_2  = 8'hAA;
   localparam logic [7:0] ADDR_ENABLE_3  = 8'hAB;
   localparam logic [7:0] ADDR_BANK_EXT  = 8'h94;
   localparam logic [7:0] ADDR_BANK_AUX  = 8'h95;
   localparam logic [7:0] ADDR_BANK_SP   = 8'h96;
   // ------------------------------------------------------------
   // reset values and field layout
   // ------------------------------------------------------------
   localparam logic [7:0] RESET_BYTE     = 8'h00;
   localparam logic [7:0] PRIO_MASK      = 8'h3F;
   localparam logic [7:0] FLAGS_B_MASK   = 8'hC3;
   localparam logic [7:0] ENABLE_MASK    = 8'h3F;
   localparam int         GATE_BIT       = 7;
   localparam int         NUM_GROUPS     = 6;
   localparam int         NUM_SOURCES    = 24;
   localparam logic [15:0] VEC_BASE      = 16'h0003;
   localparam logic [15:0] VEC_STEP      = 16'h0008;
   localparam logic [15:0] VEC_GAP       = 16'h0010;
   localparam logic [4:0]  GAP_FROM      = 5'h0E;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PIC_IDLE    = 3'b000,
      PIC_PUSH    = 3'b001,
      PIC_CALL    = 3'b010,
      PIC_POP     = 3'b011,
      PIC_RESTORE = 3'b100
   } pic_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pic_sfr_req_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] data;
   } pic_stack_t;
endpackage : pic_pkg

/* verilog/pic_top.sv */
// pic_top: priority interrupt controller with bank-extension stacking
// assumes peripheral requests on clk; external pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module pic_top (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   // register port
   input  wire pic_pkg::pic_sfr_req_t sfr_req,
   output var  logic [7:0]           sfr_rdata,
   // peripheral requests, same clock
   input  wire logic [7:0]           periph_req_a,
   input  wire logic                 channel_switch_req,
   input  wire logic                 converter_wakeup_req,
   // core-side request flags kept outside this block
   input  wire logic [5:0]           std_req,
   // extra external pins and edge selects
   input  wire logic                 extra_ext0_pin,
   input  wire logic                 extra_ext1_pin,
   input  wire logic [3:0]           extra_edge_sel,
   // core sequencer
   input  wire logic                 call_ack,
   input  wire logic                 reti,
   output var  logic                 call_req,
   output var  logic [15:0]          call_vector,
   // bank-extension stack
   output var  pic_pkg::pic_stack_t  stack,
   input  wire logic [7:0]           stack_data_in,
   output var  logic [7:0]           bank_extension
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] flags_a_reg, flags_b_reg, prio_lo_reg, prio_hi_reg;
   logic [7:0] en_reg [4];
   logic [7:0] bank_ext_reg, bank_aux_reg, bank_sp_reg;
   logic [7:0] periph_a_q_reg;
   logic [1:0] periph_b_q_reg;
   logic [1:0] ext_s1_reg, ext_s2_reg, ext_q_reg;
   logic [3:0] active_reg;
   logic [1:0] cur_lvl_reg, sel_lvl_reg;
   logic [15:0] vec_reg;
   logic        call_req_reg;
   pic_pkg::pic_state_t state_reg, state_next;

   function automatic logic [15:0] vec_of(input logic [4:0] idx);
      logic [15:0] v;
      v = pic_pkg::VEC_BASE + pic_pkg::VEC_STEP * {11'h000, idx};
      if (idx >= pic_pkg::GAP_FROM) begin
         v = v + pic_pkg::VEC_GAP;
      end
      return v;
   endfunction : vec_of

   function automatic logic wr_hit(input pic_pkg::pic_sfr_req_t r, input logic [7:0] a);
      return r.wr && (r.addr == a);
   endfunction : wr_hit

   // ------------------------------------------------------------
   // edge capture
   // ------------------------------------------------------------
   wire [7:0] rise_a  = periph_req_a & ~periph_a_q_reg;
   wire [1:0] rise_b  = {channel_switch_req, converter_wakeup_req} & ~periph_b_q_reg;
   wire [1:0] ext_r   = ext_s2_reg & ~ext_q_reg;
   wire [1:0] ext_f   = ~ext_s2_reg & ext_q_reg;
   wire       ext0_ev = (ext_r[0] & extra_edge_sel[1]) | (ext_f[0] & extra_edge_sel[0]);
   wire       ext1_ev = (ext_r[1] & extra_edge_sel[3]) | (ext_f[1] & extra_edge_sel[2]);
   wire [7:0] set_b   = {rise_b, 4'h0, ext1_ev, ext0_ev};

   wire       wr_a    = wr_hit(sfr_req, pic_pkg::ADDR_FLAGS_A);
   wire       wr_b    = wr_hit(sfr_req, pic_pkg::ADDR_FLAGS_B);
   wire [7:0] flags_a_next = (wr_a ? sfr_req.wdata : flags_a_reg) | rise_a;
   wire [7:0] flags_b_next = ((wr_b ? sfr_req.wdata : flags_b_reg) | set_b)
                             & pic_pkg::FLAGS_B_MASK;

   // ------------------------------------------------------------
   // source matrix: row = enable register, column = group
   // ------------------------------------------------------------
   wire [5:0] src_row [4];
   assign src_row[0] = std_req | {flags_a_reg[6], 5'h00};
   assign src_row[1] = {flags_a_reg[3], flags_a_reg[4], flags_b_reg[1],
                        flags_a_reg[5], flags_b_reg[0], 1'b0};
   assign src_row[2] = {flags_a_reg[0], flags_a_reg[1], flags_b_reg[7],
                        flags_a_reg[2], 2'b00};
   assign src_row[3] = {flags_b_reg[6], flags_a_reg[7], 4'h0};

   logic [23:0] pend;
   logic [1:0]  grp_lvl [6];
   always_comb begin
      for (int g = 0; g < pic_pkg::NUM_GROUPS; g++) begin
         grp_lvl[g] = {prio_hi_reg[g], prio_lo_reg[g]};
         for (int r = 0; r < 4; r++) begin
            pend[g*4+r] = src_row[r][g] & en_reg[r][g]
                          & en_reg[0][pic_pkg::GATE_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // arbitration
   // ------------------------------------------------------------
   logic       win_valid;
   logic [1:0] win_lvl;
   logic [4:0] win_idx;
   always_comb begin
      win_valid = 1'b0;
      win_lvl   = 2'b00;
      win_idx   = 5'h00;
      for (int l = 3; l >= 0; l--) begin
         for (int s = 0; s < pic_pkg::NUM_SOURCES; s++) begin
            if (!win_valid && pend[s] && (grp_lvl[s/4] == 2'(l))) begin
               win_valid = 1'b1;
               win_lvl   = 2'(l);
               win_idx   = 5'((s % 4) * 6 + s / 4);
            end
         end
      end
   end

   wire busy    = |active_reg;
   wire preempt = win_valid && (!busy || (win_lvl > cur_lvl_reg));

   logic [1:0] top_after;
   logic [3:0] act_left;
   always_comb begin
      act_left = active_reg;
      act_left[cur_lvl_reg] = 1'b0;
      top_after = 2'b00;
      for (int l = 0; l < 4; l++) begin
         if (act_left[l]) begin
            top_after = 2'(l);
         end
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         pic_pkg::PIC_IDLE: begin
            if (reti && busy) begin
               state_next = pic_pkg::PIC_POP;
            end else if (preempt) begin
               state_next = pic_pkg::PIC_PUSH;
            end
         end
         pic_pkg::PIC_PUSH: begin
            state_next = pic_pkg::PIC_CALL;
         end
         pic_pkg::PIC_CALL: begin
            if (call_ack) begin
               state_next = pic_pkg::PIC_IDLE;
            end
         end
         pic_pkg::PIC_POP: begin
            state_next = pic_pkg::PIC_RESTORE;
         end
         pic_pkg::PIC_RESTORE: begin
            state_next = pic_pkg::PIC_IDLE;
         end
         default: begin
            state_next = pic_pkg::PIC_IDLE;
         end
      endcase
   end

   wire in_idle = state_reg == pic_pkg::PIC_IDLE;
   wire start_push = in_idle && !(reti && busy) && preempt;
   wire start_pop  = in_idle && reti && busy;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg    <= pic_pkg::PIC_IDLE;
         active_reg   <= 4'h0;
         cur_lvl_reg  <= 2'b00;
         sel_lvl_reg  <= 2'b00;
         vec_reg      <= 16'h0000;
         call_req_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (start_push) begin
            sel_lvl_reg <= win_lvl;
            vec_reg     <= vec_of(win_idx);
         end
         if (state_reg == pic_pkg::PIC_PUSH) begin
            call_req_reg            <= 1'b1;
            active_reg[sel_lvl_reg] <= 1'b1;
            cur_lvl_reg             <= sel_lvl_reg;
         end else if (call_ack) begin
            call_req_reg <= 1'b0;
         end
         if (start_pop) begin
            active_reg  <= act_left;
            cur_lvl_reg <= top_after;
         end
      end
   end

   // ------------------------------------------------------------
   // bank-extension stack
   // ------------------------------------------------------------
   pic_pkg::pic_stack_t stack_next;
   always_comb begin
      stack_next       = '0;
      stack_next.addr  = bank_sp_reg;
      if (start_push) begin
         stack_next.wr   = 1'b1;
         stack_next.data = bank_ext_reg;
      end else if (state_reg == pic_pkg::PIC_POP) begin
         stack_next.rd = 1'b1;
      end
   end

   logic [7:0] bank_ext_next;
   always_comb begin
      bank_ext_next = bank_ext_reg;
      if (wr_hit(sfr_req, pic_pkg::ADDR_BANK_EXT)) begin
         bank_ext_next = sfr_req.wdata;
      end
      if (state_reg == pic_pkg::PIC_PUSH) begin
         bank_ext_next = {bank_aux_reg[3:0], bank_aux_reg[3:0]};
      end else if (state_reg == pic_pkg::PIC_RESTORE) begin
         bank_ext_next = stack_data_in;
      end
   end

   logic [7:0] bank_sp_next;
   always_comb begin
      bank_sp_next = bank_sp_reg;
      if (wr_hit(sfr_req, pic_pkg::ADDR_BANK_SP)) begin
         bank_sp_next = sfr_req.wdata;
      end
      if (state_reg == pic_pkg::PIC_PUSH) begin
         bank_sp_next = bank_sp_reg + 8'h01;
      end else if (start_pop) begin
         bank_sp_next = bank_sp_reg - 8'h01;
      end
   end

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   wire [7:0] ra = sfr_req.addr;
   wire [7:0] rd_mux =
      (ra == pic_pkg::ADDR_FLAGS_A)   ? flags_a_reg  :
      (ra == pic_pkg::ADDR_FLAGS_B)   ? flags_b_reg  :
      (ra == pic_pkg::ADDR_PRIO_LOW)  ? prio_lo_reg  :
      (ra == pic_pkg::ADDR_PRIO_HIGH) ? prio_hi_reg  :
      (ra == pic_pkg::ADDR_ENABLE_0)  ? en_reg[0]    :
      (ra == pic_pkg::ADDR_ENABLE_1)  ? en_reg[1]    :
      (ra == pic_pkg::ADDR_ENABLE_2)  ? en_reg[2]    :
      (ra == pic_pkg::ADDR_ENABLE_3)  ? en_reg[3]    :
      (ra == pic_pkg::ADDR_BANK_EXT)  ? bank_ext_reg :
      (ra == pic_pkg::ADDR_BANK_AUX)  ? bank_aux_reg :
      (ra == pic_pkg::ADDR_BANK_SP)   ? bank_sp_reg  : 8'h00;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flags_a_reg    <= pic_pkg::RESET_BYTE;
         flags_b_reg    <= pic_pkg::RESET_BYTE;
         prio_lo_reg    <= pic_pkg::RESET_BYTE;
         prio_hi_reg    <= pic_pkg::RESET_BYTE;
         for (int i = 0; i < 4; i++) begin
            en_reg[i] <= pic_pkg::RESET_BYTE;
         end
         bank_ext_reg   <= pic_pkg::RESET_BYTE;
         bank_aux_reg   <= pic_pkg::RESET_BYTE;
         bank_sp_reg    <= pic_pkg::RESET_BYTE;
         periph_a_q_reg <= 8'h00;
         periph_b_q_reg <= 2'b00;
         ext_s1_reg     <= 2'b00;
         ext_s2_reg     <= 2'b00;
         ext_q_reg      <= 2'b00;
         sfr_rdata      <= 8'h00;
         stack          <= '0;
      end else begin
         periph_a_q_reg <= periph_req_a;
         periph_b_q_reg <= {channel_switch_req, converter_wakeup_req};
         ext_s1_reg     <= {extra_ext1_pin, extra_ext0_pin};
         ext_s2_reg     <= ext_s1_reg;
         ext_q_reg      <= ext_s2_reg;
         flags_a_reg    <= flags_a_next;
         flags_b_reg    <= flags_b_next;
         if (wr_hit(sfr_req, pic_pkg::ADDR_PRIO_LOW)) begin
            prio_lo_reg <= sfr_req.wdata & pic_pkg::PRIO_MASK;
         end
         if (wr_hit(sfr_req, pic_pkg::ADDR_PRIO_HIGH)) begin
            prio_hi_reg <= sfr_req.wdata & pic_pkg::PRIO_MASK;
         end
         if (wr_hit(sfr_req, pic_pkg::ADDR_ENABLE_0)) begin
            en_reg[0] <= sfr_req.wdata;
         end
         if (wr_hit(sfr_req, pic_pkg::ADDR_ENABLE_1)) begin
            en_reg[1] <= sfr_req.wdata & pic_pkg::ENABLE_MASK;
         end
         if (wr_hit(sfr_req, pic_pkg::ADDR_ENABLE_2)) begin
            en_reg[2] <= sfr_req.wdata & pic_pkg::ENABLE_MASK;
         end
         if (wr_hit(sfr_req, pic_pkg::ADDR_ENABLE_3)) begin
            en_reg[3] <= sfr_req.wdata & pic_pkg::ENABLE_MASK;
         end
         if (wr_hit(sfr_req, pic_pkg::ADDR_BANK_AUX)) begin
            bank_aux_reg <= sfr_req.wdata;
         end
         bank_ext_reg   <= bank_ext_next;
         bank_sp_reg    <= bank_sp_next;
         sfr_rdata      <= sfr_req.rd ? rd_mux : 8'h00;
         stack          <= stack_next;
      end
   end

   assign call_req       = call_req_reg;
   assign call_vector    = vec_reg;
   assign bank_extension = bank_ext_reg;
endmodule : pic_top
`default_nettype wire
